//--- logic/rx_ctrl_cfg.svh
`ifndef RX_CTRL_CFG_SVH
`define RX_CTRL_CFG_SVH

// ----------------------------------------
// register offsets within one port, port and group strides, port counts
// ----------------------------------------
`define OFS_RX_HDLC_CONTROL 12'h010
`define OFS_RX_HDLC_BIT_SUPPRESS 12'h011
`define OFS_RX_CHANNEL_MONITOR_SELECT 12'h012
`define OFS_RX_SIGNALING_CONTROL 12'h013
`define PORT_STRIDE 16'h0200
`define GROUP_STRIDE 16'h2000
`define PORTS_PER_GROUP 8
`define NUM_PORTS 16

// ----------------------------------------
// field positions, write masks and reset value
// ----------------------------------------
`define RHC_CRC_DISPLAY_BIT 7
`define RHC_RESET_BIT 6
`define RHC_MAPPING_BIT 5
`define SIG_FORCE_ONES_BIT 4
`define SIG_FORCE_FREEZE_BIT 2
`define SIG_FREEZE_ENABLE_BIT 1
`define SIG_INTEGRATION_BIT 0
`define RHC_WRITE_MASK 8'hFF
`define SUPPRESS_WRITE_MASK 8'hFF
`define MONITOR_WRITE_MASK 8'h1F
`define SIGNALING_WRITE_MASK 8'h17
`define RESET_VALUE 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define HDLC_RESET_FRAMES 2
`define INTEGRATION_MULTIFRAMES 3

`endif

//--- logic/rx_ctrl_pkg.sv
package rx_ctrl_pkg;
  typedef enum logic [2:0] {
    RST_IDLE = 3'b001,
    RST_WAIT = 3'b010,
    RST_DONE = 3'b100
  } hdlc_rst_state_t;
  typedef logic [7:0] reg8_t;
endpackage : rx_ctrl_pkg

//--- logic/receive_hdlc_signaling_ctrl.sv
// Behaviour
// [RL1] crc display bit makes hdlc write crc-16 bytes after last octet
// [RL2] writing reset bit resets hdlc, flushes fifo, bit self-clears
// [RL3] hdlc reset and bit clear finish within two received frames
// [RL4] mapping select picks timeslot, or fdl (t1) / sa bits (e1)
// [RL5] five-bit timeslot select, zero is channel 1, ones channel 32
// [RL6] new timeslot select takes effect only after an hdlc reset
// [RL7] suppress bit n excludes channel bit n+1 from hdlc use
// [RL8] five-bit monitor select picks ds0 copied into monitor data
// [RL9] t1: signaling bit 4 forces enabled channels' signaling to ones
// [RL10] port copies sit at base plus 200h per port and 2000h per eight
// [RL11] e1: signaling bit 4 adds all-zero timeslot 16 resync criterion
// [RL12] force freeze freezes signaling and reinserted data, beats enable
// [RL13] freeze enable permits freezing on a freeze event
// [RL14] integration on: change reported after three stable multiframes
// [RL15] unused bits read zero, ignore writes; all fields reset to zero
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "rx_ctrl_cfg.svh"
module receive_hdlc_signaling_ctrl
  import rx_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // framer status, per port, same clock
  input wire logic [15:0] e1_mode,
  input wire logic [15:0] frame_start,
  input wire logic [15:0] multiframe_start,
  input wire logic [15:0] freeze_event,
  input wire logic [15:0] monitor_tick,
  input wire logic [127:0] monitor_ds0,
  // hdlc controls, per port
  output logic [15:0] crc_display,
  output logic [15:0] hdlc_reset,
  output logic [15:0] hdlc_use_fdl,
  output logic [15:0] hdlc_use_sa,
  output logic [79:0] hdlc_timeslot,
  output logic [127:0] hdlc_bit_enable,
  output logic [79:0] monitor_timeslot,
  // signaling controls, per port
  output logic [15:0] force_signaling_ones,
  output logic [15:0] multiframe_resync_select,
  output logic [15:0] signaling_freeze,
  output logic [15:0] signaling_integration_enable,
  output logic [15:0] integration_multiframes
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns valid bit and binary port number; clear valid bit means unmapped
  // [RL10] per-port address
  function automatic logic [4:0] decode_port(input logic [15:0] a);
    logic [4:0] r;
    logic [3:0] p;
    r = 5'h00;
    p = {a[13], a[11:9]};
    if (a[15:14] == 2'h0 && a[12] == 1'b0 && a[8:2] == 7'h04 && p[2:0] == a[11:9]) begin
      r = {1'b1, p};
    end
    return r;
  endfunction : decode_port

  logic [4:0] wr_dec;
  logic [4:0] rd_dec;
  assign wr_dec = decode_port(addr);
  assign rd_dec = wr_dec;

  reg8_t rdata_next;
  reg8_t rdata_reg;
  assign rdata = rdata_reg;

  reg8_t rhc_reg [`NUM_PORTS];
  reg8_t sup_reg [`NUM_PORTS];
  reg8_t mon_reg [`NUM_PORTS];
  reg8_t sig_reg [`NUM_PORTS];
  reg8_t mon_data_reg [`NUM_PORTS];

  // ----------------------------------------
  // read path: one cycle later, unmapped reads zero
  // ----------------------------------------
  always_comb begin
    rdata_next = `RESET_VALUE;
    if (rd_stb && rd_dec[4]) begin
      unique case (addr[1:0])
        2'h0: rdata_next = rhc_reg[rd_dec[3:0]];
        2'h1: rdata_next = sup_reg[rd_dec[3:0]];
        2'h2: rdata_next = mon_reg[rd_dec[3:0]];
        2'h3: rdata_next = sig_reg[rd_dec[3:0]];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `RESET_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // per-port registers and behaviour
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g++) begin : port
      logic hit;
      hdlc_rst_state_t state_reg;
      logic [1:0] frames_reg;
      logic [4:0] active_ts_reg;
      assign hit = wr_stb && wr_dec[4] && (wr_dec[3:0] == 4'(g));

      // [RL15] masked writes, zero reset
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sup_reg[g] <= `RESET_VALUE;
          mon_reg[g] <= `RESET_VALUE;
          sig_reg[g] <= `RESET_VALUE;
        end else if (hit) begin
          unique case (addr[1:0])
            2'h1: sup_reg[g] <= wdata & `SUPPRESS_WRITE_MASK;
            2'h2: mon_reg[g] <= wdata & `MONITOR_WRITE_MASK;
            2'h3: sig_reg[g] <= wdata & `SIGNALING_WRITE_MASK;
            default: ;
          endcase
        end
      end

      // [RL2] self-clearing reset bit; cleared in RST_DONE unless a write to the register lands in the same cycle
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          rhc_reg[g] <= `RESET_VALUE;
        end else if (hit && addr[1:0] == 2'h0) begin
          rhc_reg[g] <= (wdata & `RHC_WRITE_MASK) |
            (rhc_reg[g] & (8'h01 << `RHC_RESET_BIT));
        end else if (state_reg == RST_DONE) begin
          rhc_reg[g][`RHC_RESET_BIT] <= 1'b0;
        end
      end

      // [RL3] reset held at most two frames
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          state_reg <= RST_IDLE;
          frames_reg <= 2'h0;
        end else begin
          unique case (state_reg)
            RST_IDLE: begin
              frames_reg <= 2'h0;
              if (rhc_reg[g][`RHC_RESET_BIT]) begin
                state_reg <= RST_WAIT;
              end
            end
            RST_WAIT: begin
              if (frame_start[g]) begin
                frames_reg <= frames_reg + 2'h1;
                // two full frame boundaries needed; the second one ends the wait
                if (frames_reg == 2'(`HDLC_RESET_FRAMES - 1)) begin
                  state_reg <= RST_DONE;
                end
              end
            end
            RST_DONE: state_reg <= RST_IDLE;
            default: state_reg <= RST_IDLE;
          endcase
        end
      end

      // [RL6] timeslot latched at reset
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          active_ts_reg <= 5'h00;
        end else if (state_reg == RST_DONE) begin
          active_ts_reg <= rhc_reg[g][4:0];
        end
      end

      // [RL8] monitor capture
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mon_data_reg[g] <= `RESET_VALUE;
        end else if (monitor_tick[g]) begin
          mon_data_reg[g] <= monitor_ds0[g*8 +: 8];
        end
      end

      // [RL1] crc display
      assign crc_display[g] = rhc_reg[g][`RHC_CRC_DISPLAY_BIT];
      // [RL2] hdlc reset and flush
      assign hdlc_reset[g] = (state_reg != RST_IDLE);
      // [RL4] mapping select
      assign hdlc_use_fdl[g] = rhc_reg[g][`RHC_MAPPING_BIT] & ~e1_mode[g];
      assign hdlc_use_sa[g] = rhc_reg[g][`RHC_MAPPING_BIT] & e1_mode[g];
      // [RL5] timeslot code, zero is channel 1
      assign hdlc_timeslot[g*5 +: 5] = active_ts_reg;
      // [RL7] bit suppress
      assign hdlc_bit_enable[g*8 +: 8] = ~sup_reg[g];
      assign monitor_timeslot[g*5 +: 5] = mon_reg[g][4:0];
      // [RL9] t1 force ones
      assign force_signaling_ones[g] = sig_reg[g][`SIG_FORCE_ONES_BIT] & ~e1_mode[g];
      // [RL11] e1 resync criterion
      assign multiframe_resync_select[g] = sig_reg[g][`SIG_FORCE_ONES_BIT] & e1_mode[g];
      // [RL12] force freeze overrides
      // [RL13] freeze enable
      assign signaling_freeze[g] = sig_reg[g][`SIG_FORCE_FREEZE_BIT] |
        (sig_reg[g][`SIG_FREEZE_ENABLE_BIT] & freeze_event[g]);
      // [RL14] integration
      assign signaling_integration_enable[g] = sig_reg[g][`SIG_INTEGRATION_BIT];
      assign integration_multiframes[g] = sig_reg[g][`SIG_INTEGRATION_BIT];
    end
  endgenerate

endmodule : receive_hdlc_signaling_ctrl

//--- sim/rx_ctrl_asserts.sv
`timescale 1ns/10ps
module rx_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  // port controls
  input wire logic [15:0] e1_mode,
  input wire logic [15:0] frame_start,
  input wire logic [15:0] crc_display,
  input wire logic [15:0] hdlc_reset,
  input wire logic [127:0] hdlc_bit_enable,
  input wire logic [79:0] monitor_timeslot,
  input wire logic [15:0] force_signaling_ones,
  input wire logic [15:0] signaling_freeze
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] frames_reg;
  // frames counted only while pending, so a late finish saturates at three
  always_ff @(posedge clk) begin
    if (!rst_n || !hdlc_reset[0]) frames_reg <= 2'h0;
    else if (frame_start[0] && frames_reg != 2'h3) frames_reg <= frames_reg + 2'h1;
  end
  crc_bit_a: assert property (wr_stb && addr == 16'h0010
    |=> crc_display[0] == $past(wdata[7])) else $error("crc display wrong");
  reset_start_a: assert property (wr_stb && addr == 16'h0010 && wdata[6]
    |-> ##2 hdlc_reset[0]) else $error("hdlc reset not started");
  reset_bound_a: assert property (frames_reg != 2'h3)
    else $error("hdlc reset too slow");
  suppress_map_a: assert property (wr_stb && addr == 16'h0011
    |=> hdlc_bit_enable[7:0] == ~$past(wdata)) else $error("bit enable wrong");
  monitor_sel_a: assert property (wr_stb && addr == 16'h0012
    |=> monitor_timeslot[4:0] == $past(wdata[4:0])) else $error("monitor select wrong");
  force_ones_a: assert property (wr_stb && addr == 16'h0013 && !e1_mode[0]
    |=> force_signaling_ones[0] == $past(wdata[4])) else $error("force ones wrong");
  force_freeze_a: assert property (wr_stb && addr == 16'h0013 && wdata[2]
    |=> signaling_freeze[0]) else $error("forced freeze missing");
  read_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : rx_ctrl_asserts

//--- sim/receive_hdlc_signaling_ctrl_tb.sv
`timescale 1ns/10ps
module receive_hdlc_signaling_ctrl_tb;
  import rx_ctrl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, pend = 1'b0, m;
  logic [15:0] addr = 16'h0000, e1_mode = 16'hFF00, frame_start = 16'h0000;
  logic [15:0] freeze_event = 16'h0000, lfsr = 16'h9571, crc_display, hdlc_reset;
  logic [15:0] hdlc_use_fdl, hdlc_use_sa, force_signaling_ones, multiframe_resync_select;
  logic [15:0] signaling_freeze, signaling_integration_enable, integration_multiframes;
  logic [79:0] hdlc_timeslot, monitor_timeslot;
  logic [127:0] hdlc_bit_enable;
  logic [7:0] rdata;
  logic [5:0] fc = 6'h00;
  reg8_t wdata = 8'h00, rd_q[$], v[4];
  reg8_t masks[4] = '{8'hFF, 8'hFF, 8'h1F, 8'h17};
  int num_errors = 0, samples_checked = 0, k, p;
  always #10 clk = ~clk;
  // frame pulses every 64 cycles keep the reset wait short
  always @(posedge clk) begin
    fc <= fc + 6'h01;
    frame_start <= {16{fc == 6'h00}};
  end
  receive_hdlc_signaling_ctrl receive_hdlc_signaling_ctrl_i (.clk, .rst_n, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .e1_mode, .frame_start, .multiframe_start(16'h0000),
    .freeze_event, .monitor_tick(16'h0000), .monitor_ds0(128'h0), .crc_display,
    .hdlc_reset, .hdlc_use_fdl, .hdlc_use_sa, .hdlc_timeslot, .hdlc_bit_enable,
    .monitor_timeslot, .force_signaling_ones, .multiframe_resync_select, .signaling_freeze,
    .signaling_integration_enable, .integration_multiframes);
  function automatic logic [15:0] base(input int n);
    return 16'h0010 + 16'(n % 8) * 16'h0200 + 16'(n / 8) * 16'h2000;
  endfunction : base
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (e !== s) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [15:0] a, input reg8_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    if (!w) rd_q.push_back(d);
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  endtask : bus
  task automatic wait_rst(input logic lvl);
    for (k = 0; k < 200 && hdlc_reset[0] !== lvl; k++) @(negedge clk);
    if (k == 200) begin
      num_errors++;
      end_of_test();
    end
  endtask : wait_rst
  // read data lands one cycle after the strobe
  always @(negedge clk) begin
    if (pend) chk("rdata", rd_q.pop_front(), rdata);
    pend = rd_stb;
  end
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 5; k++) bus(1'b0, 16'h0010 + 16'(k), 8'h00);
    chk("enable", {128{1'b1}}, hdlc_bit_enable);
    $display("reset values done");
    for (p = 0; p < 16; p++) begin
      for (int r = 0; r < 4; r++) begin
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        v[r] = lfsr[7:0] & (r == 0 ? 8'hBF : masks[r]);
        bus(1'b1, base(p) + 16'(r), lfsr[7:0] & (r == 0 ? 8'hBF : 8'hFF));
        bus(1'b0, base(p) + 16'(r), v[r]);
      end
      @(negedge clk);
      m = e1_mode[p];
      chk("hdlc", {v[0][7], v[0][5] & !m, v[0][5] & m, ~v[1]},
        {crc_display[p], hdlc_use_fdl[p], hdlc_use_sa[p], hdlc_bit_enable[p*8 +: 8]});
      chk("sig", {v[2][4:0], v[3][4] & !m, v[3][4] & m, v[3][2], v[3][0], v[3][0]},
        {monitor_timeslot[p*5 +: 5], force_signaling_ones[p], multiframe_resync_select[p],
        signaling_freeze[p], signaling_integration_enable[p], integration_multiframes[p]});
    end
    chk("timeslot", 80'h0, hdlc_timeslot);
    $display("port map done");
    bus(1'b1, 16'h0010, 8'h5F);
    wait_rst(1'b1);
    chk("ts_wait", 5'h00, hdlc_timeslot[4:0]);
    wait_rst(1'b0);
    chk("ts_new", 5'h1F, hdlc_timeslot[4:0]);
    bus(1'b0, 16'h0010, 8'h1F);
    $display("hdlc reset done");
    bus(1'b1, 16'h0013, 8'h04);
    @(negedge clk);
    chk("force_freeze", 1'b1, signaling_freeze[0]);
    bus(1'b1, 16'h0013, 8'h06);
    @(negedge clk);
    chk("force_beats_enable", 1'b1, signaling_freeze[0]);
    bus(1'b1, 16'h0013, 8'h02);
    @(negedge clk);
    chk("no_event", 1'b0, signaling_freeze[0]);
    @(posedge clk);
    freeze_event <= 16'h0001;
    @(negedge clk);
    chk("event", 1'b1, signaling_freeze[0]);
    $display("freeze done");
    end_of_test();
  end
endmodule : receive_hdlc_signaling_ctrl_tb
bind receive_hdlc_signaling_ctrl rx_ctrl_asserts rx_ctrl_asserts_i (.clk, .rst_n, .addr,
  .wdata, .wr_stb, .rd_stb, .rdata, .e1_mode, .frame_start, .crc_display, .hdlc_reset,
  .hdlc_bit_enable, .monitor_timeslot, .force_signaling_ones, .signaling_freeze);
